/* rts_pkg.sv */
// Purpose: Shared constants and carriers for the reset terminal supervisor
// Assumes: 125 MHz core clock
// Notes:   Register indices are word addresses on the plain register port
package rts_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam longint CLK_HZ           = 64'h0000_0000_0773_5940; // 125 MHz
  localparam longint SANITY_TIMEOUT_S = 64'h0000_0000_0000_0018; // 24 s
  localparam longint WARN_LEAD_MS     = 64'h0000_0000_0000_02EE; // 0.75 s as ms
  localparam longint SANITY_CYC_L     = CLK_HZ * SANITY_TIMEOUT_S;
  localparam longint WARN_CYC_L       = (CLK_HZ * WARN_LEAD_MS) / 64'h0000_0000_0000_03E8;
  localparam logic [31:0] SANITY_CYC  = SANITY_CYC_L[31:0];
  localparam logic [31:0] WARN_CYC    = WARN_CYC_L[31:0];
  localparam logic [3:0]  CPU_RST_CYC = 4'h8;

  // ************************************************************
  // Memory sizes of the microcontroller and firmware store
  // ************************************************************
  localparam int unsigned PROG_MEM_BYTES = 32'h0000_8000;
  localparam int unsigned SRAM_BYTES     = 32'h0000_8000;
  localparam int unsigned EEPROM_BYTES   = 32'h0000_2000;
  localparam int unsigned FW_BYTES       = 32'h0020_0000;
  localparam logic [15:0] EEPROM_BASE    = 16'h8000;

  // ************************************************************
  // Register map (word index)
  // ************************************************************
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h1;
  localparam logic [3:0] REG_SANITY   = 4'h2;
  localparam logic [3:0] REG_OOB      = 4'h3;
  localparam logic [3:0] REG_BOARD    = 4'h4;
  localparam logic [3:0] REG_ID_INDEX = 4'h5;
  localparam logic [3:0] REG_ID_DATA  = 4'h6;
  localparam logic [31:0] CTRL_RST_VAL = 32'h0000_0010; // master indication inactive

  // CTRL fields
  localparam int CTRL_CPU_RST   = 0;
  localparam int CTRL_JAM       = 1;
  localparam int CTRL_SAN_DIS   = 2;
  localparam int CTRL_NMI       = 3;
  localparam int CTRL_MASTER_N  = 4;
  localparam int CTRL_SLAVE     = 5;
  localparam int CTRL_SPLIT     = 6;
  localparam int CTRL_BYPASS    = 7;
  localparam int CTRL_CHB_LO    = 8;

  typedef enum logic [1:0] {
    RTS_CHB_LOOP  = 2'h0,
    RTS_CHB_RS232 = 2'h1,
    RTS_CHB_RS422 = 2'h2
  } rts_chb_sel_t;

  // Processor card line bundle
  typedef struct packed {
    logic reset;
    logic jam;
    logic sanity_dis;
    logic nmi;
  } rts_cpu_ctl_t;

  // Processor card status bundle
  typedef struct packed {
    logic       active;
    logic       synced;
    logic       clk_fail;
    logic       clk_act;
    logic       oos;
    logic [7:0] board;
  } rts_cpu_stat_t;

endpackage : rts_pkg

/* rts_supervisor.sv */
// Purpose: Supervisory logic beside one processor card of a duplicated pair
// Assumes: Character and message strobes come from logic on core_clk
// Notes:   Power fail acts as an extra synchronous reset of all but the pin synchronisers and identity memory
// Notes on behaviour
// - Sanity timeout after 24 s resets microcontroller
// - Warning interrupt 0.75 s before that reset
// - Power fail holds card in reset, except pin synchronisers and identity memory
// - Out-of-band messages to microcontroller; slave resets processor
// - Drive backplane master indication to boards
// - Processor reset and jam control outputs
// - Processor sanity disable and top interrupt
// - Twins exchange jam; if both jammed, side without JAM_PRIORITY yields
// - Port 3 wired to processor channel A
// - Serial channel A to local terminal
// - Channel B loopback, RS232 or RS422
// - Simplex bypass skips own channel B
// - Identity memory answers 32-bit, no parity
// - Firmware store parity depends on mode
// - Program, SRAM, EEPROM memories with registers
// - Red inactive indicator, green sync indicator
// - Green activity indicator while card active
// - Splitter mode set, exchanged with twin
// - Captive office strap readable
// - While jammed, present processor status continuously
`timescale 1ns/1ps
`default_nettype none
module rts_supervisor
  import rts_pkg::*;
#(
  parameter logic [31:0] SANITY_CYCLES = SANITY_CYC,
  parameter logic [31:0] WARN_CYCLES   = WARN_CYC,
  parameter int          ID_DEPTH      = 16,
  parameter bit          JAM_PRIORITY  = 1'b0
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          clk_en,
  // Register port
  input  wire logic [3:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata,
  // Watched character strobes
  input  wire logic          cpu_char_rx,
  input  wire logic          local_char_rx,
  input  wire logic          remote_char_rx,
  output logic               mcu_warn_irq,
  output logic               mcu_reset,
  input  wire logic          power_fail_n,
  // Out-of-band links
  input  wire logic          oob_msg_valid,
  input  wire logic [7:0]    oob_msg,
  output logic               master_indication_n,
  // Processor card
  output rts_cpu_ctl_t       cpu_ctl,
  input  wire rts_cpu_stat_t cpu_stat_pin,
  output rts_cpu_stat_t      cpu_stat_disp,
  // Twin card
  input  wire logic          twin_jam_in,
  output logic               jam_status_out,
  input  wire logic          split_in,
  output logic               split_out,
  input  wire logic          strap_captive,
  // Serial routing
  input  wire logic          port3_txd,
  output logic               port3_rxd,
  input  wire logic          cpu_cha_txd,
  output logic               cpu_cha_rxd,
  input  wire logic          scc_a_txd,
  output logic               scc_a_rxd,
  input  wire logic          local_rxd,
  output logic               local_txd,
  input  wire logic          scc_b_txd,
  output logic               scc_b_rxd,
  input  wire logic          cpu_chb_txd,
  output logic               cpu_chb_rxd,
  input  wire logic          rs232_rxd,
  output logic               rs232_txd,
  input  wire logic          rs422_rxd,
  output logic               rs422_txd,
  // Microcontroller memory decode
  input  wire logic [15:0]   mcu_xaddr,
  input  wire logic          mcu_xstrobe,
  output logic               sram_sel,
  output logic               eeprom_sel,
  // Peripheral card bus
  input  wire logic          pb_req,
  input  wire logic          pb_id_sel,
  input  wire logic          pb_fw_sel,
  input  wire logic [23:0]   pb_addr,
  input  wire logic [31:0]   pb_fw_rdata,
  input  wire logic          fw_parity_mode,
  output logic               pb_ack,
  output logic      [31:0]   pb_rdata,
  output logic               pb_parity_en,
  output logic               pb_parity,
  // Indicators
  output logic               led_red,
  output logic               led_green_sync,
  output logic               led_green_act
);

  localparam int IDW = $clog2(ID_DEPTH);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  localparam int NSYNC = 17;
  logic [NSYNC-1:0] sync1_ff, sync2_ff;
  logic [NSYNC-1:0] pin_in;
  assign pin_in = {power_fail_n, twin_jam_in, split_in, strap_captive, cpu_stat_pin};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_ff <= {1'b1, {(NSYNC-1){1'b0}}}; // Idle levels: no false twin jam after reset
      sync2_ff <= {1'b1, {(NSYNC-1){1'b0}}};
    end else if (clk_en) begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  logic          pfail_s, twin_jam_s, split_in_s, strap_s;
  rts_cpu_stat_t stat_s;
  assign {pfail_s, twin_jam_s, split_in_s, strap_s, stat_s} =
    {~sync2_ff[16], sync2_ff[15:0]};

  // Power fail holds every flop except the pin synchronisers and identity memory in reset
  logic card_rst;
  assign card_rst = rst | pfail_s;

  // ************************************************************
  // Register state
  // ************************************************************
  logic [31:0]    ctrl_ff, nxt_ctrl;
  logic [IDW-1:0] id_idx_ff, nxt_id_idx;
  logic [7:0]     oob_data_ff, nxt_oob_data;
  logic           oob_full_ff, nxt_oob_full;
  logic [31:0]    rdata_ff, nxt_rdata;
  logic [31:0]    id_mem [ID_DEPTH];
  logic           wr_ctrl, wr_san, rd_oob;

  assign wr_ctrl = reg_wr && reg_addr == REG_CTRL;
  assign wr_san  = reg_wr && reg_addr == REG_SANITY;
  assign rd_oob  = reg_rd && reg_addr == REG_OOB;

  // ************************************************************
  // Sanity timer
  // ************************************************************
  logic [31:0] san_cnt_ff, nxt_san_cnt;
  logic        warn_ff, nxt_warn, mcu_rst_ff, nxt_mcu_rst, char_seen;

  assign char_seen = cpu_char_rx | local_char_rx | remote_char_rx;

  always_comb begin
    nxt_san_cnt = san_cnt_ff + 32'h0000_0001;
    nxt_warn    = warn_ff;
    nxt_mcu_rst = 1'b0;
    if (char_seen || wr_san) begin
      nxt_san_cnt = 32'h0000_0000;
      nxt_warn    = 1'b0;
    end else if (san_cnt_ff == SANITY_CYCLES - 32'h0000_0001) begin
      nxt_san_cnt = 32'h0000_0000;
      nxt_warn    = 1'b0;
      nxt_mcu_rst = 1'b1;
    end else if (san_cnt_ff == SANITY_CYCLES - WARN_CYCLES - 32'h0000_0001) begin
      nxt_warn    = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (card_rst) begin
      san_cnt_ff <= 32'h0000_0000;
      warn_ff    <= 1'b0;
      mcu_rst_ff <= 1'b0;
    end else if (clk_en) begin
      san_cnt_ff <= nxt_san_cnt;
      warn_ff    <= nxt_warn;
      mcu_rst_ff <= nxt_mcu_rst;
    end
  end
  assign mcu_warn_irq = warn_ff;
  assign mcu_reset    = mcu_rst_ff;

  // ************************************************************
  // Out-of-band capture and processor reset stretch
  // ************************************************************
  logic [3:0] cpu_rst_cnt_ff, nxt_cpu_rst_cnt;

  always_comb begin
    nxt_oob_data    = oob_data_ff;
    nxt_oob_full    = oob_full_ff;
    nxt_cpu_rst_cnt = cpu_rst_cnt_ff;
    if (cpu_rst_cnt_ff != 4'h0)
      nxt_cpu_rst_cnt = cpu_rst_cnt_ff - 4'h1;
    if (rd_oob)
      nxt_oob_full = 1'b0;
    // A message landing on the clearing read still sets the flag
    if (oob_msg_valid) begin
      nxt_oob_data = oob_msg;
      nxt_oob_full = 1'b1;
      if (ctrl_ff[CTRL_SLAVE])
        nxt_cpu_rst_cnt = CPU_RST_CYC;
    end
  end

  // ************************************************************
  // Control register and jam arbitration
  // ************************************************************
  logic jam_ff, nxt_jam;

  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_id_idx = id_idx_ff;
    if (wr_ctrl)
      nxt_ctrl = reg_wdata;
    if (reg_wr && reg_addr == REG_ID_INDEX)
      nxt_id_idx = reg_wdata[IDW-1:0];
    else if (reg_wr && reg_addr == REG_ID_DATA)
      nxt_id_idx = id_idx_ff + IDW'(1);
    // Only jam while the twin is free; on a tie the low side backs off
    nxt_jam = ctrl_ff[CTRL_JAM] && !(twin_jam_s && (!jam_ff || !JAM_PRIORITY));
  end

  always_ff @(posedge core_clk) begin
    if (card_rst) begin
      ctrl_ff        <= CTRL_RST_VAL;
      id_idx_ff      <= '0;
      oob_data_ff    <= 8'h00;
      oob_full_ff    <= 1'b0;
      cpu_rst_cnt_ff <= 4'h0;
      jam_ff         <= 1'b0;
    end else if (clk_en) begin
      ctrl_ff        <= nxt_ctrl;
      id_idx_ff      <= nxt_id_idx;
      oob_data_ff    <= nxt_oob_data;
      oob_full_ff    <= nxt_oob_full;
      cpu_rst_cnt_ff <= nxt_cpu_rst_cnt;
      jam_ff         <= nxt_jam;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clk_en && reg_wr && reg_addr == REG_ID_DATA)
      id_mem[id_idx_ff] <= reg_wdata;
  end

  assign cpu_ctl.reset      = ctrl_ff[CTRL_CPU_RST] | (cpu_rst_cnt_ff != 4'h0);
  assign cpu_ctl.jam        = jam_ff;
  assign cpu_ctl.sanity_dis = ctrl_ff[CTRL_SAN_DIS];
  assign cpu_ctl.nmi        = ctrl_ff[CTRL_NMI];
  assign jam_status_out     = jam_ff;
  assign master_indication_n = ctrl_ff[CTRL_MASTER_N];
  assign split_out          = ctrl_ff[CTRL_SPLIT];

  // ************************************************************
  // Read path, status display, indicators
  // ************************************************************
  logic [31:0]   status_w;
  rts_cpu_stat_t disp_ff, nxt_disp;
  assign status_w = {20'h0_0000, stat_s.oos, stat_s.clk_act, stat_s.clk_fail,
                     stat_s.synced, stat_s.active, strap_s, split_in_s,
                     twin_jam_s, jam_ff, oob_full_ff, warn_ff, 1'b0};

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_disp  = disp_ff;
    if (jam_ff)
      nxt_disp = stat_s;
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:     nxt_rdata = ctrl_ff;
        REG_STATUS:   nxt_rdata = status_w;
        REG_SANITY:   nxt_rdata = san_cnt_ff;
        REG_OOB:      nxt_rdata = {23'h00_0000, oob_full_ff, oob_data_ff};
        REG_BOARD:    nxt_rdata = {24'h00_0000, stat_s.board};
        REG_ID_INDEX: nxt_rdata = 32'(id_idx_ff);
        default:      nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (card_rst) begin
      rdata_ff <= 32'h0000_0000;
      disp_ff  <= '0;
    end else if (clk_en) begin
      rdata_ff <= nxt_rdata;
      disp_ff  <= nxt_disp;
    end
  end
  assign reg_rdata     = rdata_ff;
  assign cpu_stat_disp = disp_ff;

  assign led_red        = ~stat_s.active | stat_s.oos;
  assign led_green_sync = stat_s.synced;
  assign led_green_act  = ~card_rst;

  // ************************************************************
  // Serial routing
  // ************************************************************
  rts_chb_sel_t chb_sel;
  assign chb_sel = rts_chb_sel_t'(ctrl_ff[CTRL_CHB_LO +: 2]);

  logic [5:0] ser_ff, nxt_ser;
  always_comb begin
    logic remote_rx;
    remote_rx = (chb_sel == RTS_CHB_RS422) ? rs422_rxd : rs232_rxd;
    nxt_ser[0] = cpu_cha_txd;
    nxt_ser[1] = port3_txd;
    nxt_ser[2] = local_rxd;
    nxt_ser[3] = scc_a_txd;
    if (ctrl_ff[CTRL_BYPASS]) begin
      nxt_ser[4] = 1'b1;
      nxt_ser[5] = remote_rx;
    end else begin
      nxt_ser[4] = (chb_sel == RTS_CHB_LOOP) ? scc_b_txd : remote_rx;
      nxt_ser[5] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (card_rst)
      ser_ff <= 6'h3F;
    else if (clk_en)
      ser_ff <= nxt_ser;
  end
  logic remote_tx;
  assign remote_tx   = ctrl_ff[CTRL_BYPASS] ? cpu_chb_txd : scc_b_txd;
  assign port3_rxd   = ser_ff[0];
  assign cpu_cha_rxd = ser_ff[1];
  assign scc_a_rxd   = ser_ff[2];
  assign local_txd   = ser_ff[3];
  assign scc_b_rxd   = ser_ff[4];
  assign cpu_chb_rxd = ser_ff[5];
  assign rs232_txd   = (chb_sel == RTS_CHB_RS232) ? remote_tx : 1'b1;
  assign rs422_txd   = (chb_sel == RTS_CHB_RS422) ? remote_tx : 1'b1;

  // ************************************************************
  // Memory decode and peripheral bus answers
  // ************************************************************
  assign sram_sel   = mcu_xstrobe && mcu_xaddr < 16'(SRAM_BYTES);
  assign eeprom_sel = mcu_xstrobe && mcu_xaddr >= EEPROM_BASE
                      && mcu_xaddr < EEPROM_BASE + 16'(EEPROM_BYTES);

  logic        pb_ack_ff, pb_pen_ff, pb_par_ff;
  logic [31:0] pb_data_ff, pb_word;
  logic        pb_fw_hit;
  assign pb_fw_hit = pb_fw_sel && pb_addr < 24'(FW_BYTES);
  assign pb_word   = pb_id_sel ? id_mem[pb_addr[IDW+1:2]] : pb_fw_rdata;

  always_ff @(posedge core_clk) begin
    if (card_rst) begin
      pb_ack_ff  <= 1'b0;
      pb_pen_ff  <= 1'b0;
      pb_par_ff  <= 1'b0;
      pb_data_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      pb_ack_ff  <= pb_req && (pb_id_sel || pb_fw_hit);
      pb_pen_ff  <= pb_req && !pb_id_sel && pb_fw_hit && fw_parity_mode;
      pb_par_ff  <= ^pb_word;
      pb_data_ff <= pb_word;
    end
  end
  assign pb_ack       = pb_ack_ff;
  assign pb_rdata     = pb_data_ff;
  assign pb_parity_en = pb_pen_ff;
  assign pb_parity    = pb_par_ff & pb_pen_ff;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence quiet_s;
    clk_en && !char_seen && !wr_san;
  endsequence

  timeout_reset_a: assert property ((clk_en && !card_rst && !char_seen && !wr_san
      && san_cnt_ff == SANITY_CYCLES - 32'h0000_0001) |=> mcu_reset)
    else $error("sanity timeout gave no reset");
  warn_lead_a: assert property ((quiet_s and !card_rst
      && san_cnt_ff == SANITY_CYCLES - WARN_CYCLES - 32'h0000_0001) |=> mcu_warn_irq)
    else $error("warning not raised at lead time");
  char_restart_a: assert property ((clk_en && !card_rst && char_seen)
      |=> san_cnt_ff == 32'h0000_0000 && !mcu_warn_irq && !mcu_reset)
    else $error("character did not restart interval");
  pfail_hold_a: assert property (pfail_s |=> !cpu_ctl.jam && !mcu_warn_irq && !pb_ack)
    else $error("card not held during power fail");
  oob_slave_a: assert property ((clk_en && !card_rst && oob_msg_valid && ctrl_ff[CTRL_SLAVE]
      ##1 !card_rst[*4]) |-> cpu_ctl.reset)
    else $error("slave message did not reset processor");
  oob_keep_a: assert property ((clk_en && !card_rst && oob_msg_valid) |=> oob_full_ff)
    else $error("out-of-band message lost");
  jam_never_a: assert property ((jam_ff && twin_jam_s && !JAM_PRIORITY && clk_en && !card_rst)
      |=> !jam_ff)
    else $error("both processors jammed");
  id_no_par_a: assert property ((clk_en && !card_rst && pb_req && pb_id_sel)
      |=> pb_ack && !pb_parity_en)
    else $error("identity access carried parity");
  fw_par_a: assert property ((clk_en && !card_rst && pb_req && !pb_id_sel && pb_fw_hit)
      |=> pb_parity_en == $past(fw_parity_mode)
          && (pb_parity == ^pb_rdata || !pb_parity_en))
    else $error("firmware parity mode wrong");
  disp_jam_a: assert property ((jam_ff && clk_en && !card_rst) |=> cpu_stat_disp == $past(stat_s))
    else $error("status not presented while jammed");

endmodule : rts_supervisor
`default_nettype wire

/* rts_cpu_model.sv */
// Purpose: Processor card seen from the supervisor side
// Assumes: Driven on core_clk, one character pulse per send_char cycle
// Notes:   Serial channel A and B transmit lines echo what they receive
`timescale 1ns/1ps
`default_nettype none
module rts_cpu_model
  import rts_pkg::*;
(
  input  wire logic          core_clk,
  input  wire rts_cpu_ctl_t  cpu_ctl,
  input  wire logic          send_char,
  input  wire logic [7:0]    board,
  input  wire logic          cpu_cha_rxd,
  input  wire logic          cpu_chb_rxd,
  output rts_cpu_stat_t      cpu_stat_pin,
  output logic               cpu_char_rx,
  output logic               cpu_cha_txd,
  output logic               cpu_chb_txd
);
  // ************************************************************
  // Card behaviour
  // ************************************************************
  always_ff @(posedge core_clk) begin
    cpu_char_rx           <= send_char;
    cpu_stat_pin.active   <= !cpu_ctl.jam && !cpu_ctl.reset;
    cpu_stat_pin.synced   <= !cpu_ctl.jam;
    cpu_stat_pin.clk_fail <= 1'b0;
    cpu_stat_pin.clk_act  <= 1'b1;
    cpu_stat_pin.oos      <= cpu_ctl.jam;
    cpu_stat_pin.board    <= board;
    // Echo lets the bench see the whole path through the card
    cpu_cha_txd           <= cpu_cha_rxd;
    cpu_chb_txd           <= cpu_chb_rxd;
  end
endmodule : rts_cpu_model
`default_nettype wire

/* rts_supervisor_tb.sv */
// Purpose: Self-checking bench for the reset terminal supervisor
// Assumes: Sanity interval shortened to 40 cycles, warning lead 10
// Notes:   Ends through end_of_test, also on watchdog expiry
`timescale 1ns/1ps
`default_nettype none
module rts_supervisor_tb;
  import rts_pkg::*;
  localparam logic [31:0] SAN = 32'h0000_0028;
  localparam logic [31:0] WRN = 32'h0000_000A;
  logic core_clk, rst, clk_en, reg_wr, reg_rd, local_char_rx, remote_char_rx, power_fail_n;
  logic oob_msg_valid, twin_jam_in, split_in, strap_captive, port3_txd, scc_a_txd, local_rxd;
  logic scc_b_txd, rs232_rxd, rs422_rxd, mcu_xstrobe, pb_req, pb_id_sel, pb_fw_sel;
  logic fw_parity_mode, mcu_warn_irq, mcu_reset, master_indication_n, jam_status_out;
  logic split_out, port3_rxd, cpu_cha_rxd, scc_a_rxd, local_txd, scc_b_rxd, cpu_chb_rxd;
  logic rs232_txd, rs422_txd, sram_sel, eeprom_sel, pb_ack, pb_parity_en, pb_parity, led_red;
  logic led_green_sync, led_green_act, cpu_char_rx, cpu_cha_txd, cpu_chb_txd, send_char;
  logic [3:0]  reg_addr;
  logic [7:0]  oob_msg, board;
  logic [15:0] mcu_xaddr;
  logic [23:0] pb_addr;
  logic [31:0] reg_wdata, reg_rdata, pb_fw_rdata, pb_rdata, v;
  logic [2:0]  f;
  rts_cpu_ctl_t  cpu_ctl;
  rts_cpu_stat_t cpu_stat_pin, cpu_stat_disp;
  int n_mismatch, samples_checked, i, t_warn, t_rst;
  rts_supervisor #(.SANITY_CYCLES(SAN), .WARN_CYCLES(WRN)) u_rts_supervisor (.*);
  rts_cpu_model u_rts_cpu_model (.*);
  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic pb(input logic id, input logic [23:0] a);
    @(posedge core_clk);
    pb_req <= 1'b1; pb_id_sel <= id; pb_fw_sel <= !id; pb_addr <= a;
    @(posedge core_clk);
    pb_req <= 1'b0;
    #1 v = pb_rdata;
    f = {pb_ack, pb_parity_en, pb_parity};
  endtask : pb
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // ************************************************************
  // Clock, watchdog and tests
  // ************************************************************
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    cyc(6000);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {reg_wr, reg_rd, local_char_rx, remote_char_rx, oob_msg_valid, twin_jam_in, send_char} = '0;
    {split_in, strap_captive, mcu_xstrobe, pb_req, pb_id_sel, pb_fw_sel, fw_parity_mode} = '0;
    {port3_txd, scc_a_txd, local_rxd, scc_b_txd, rs232_rxd, rs422_rxd} = '1;
    {reg_addr, oob_msg, board, mcu_xaddr, pb_addr, reg_wdata, pb_fw_rdata} = '0;
    rst = 1'b1; clk_en = 1'b1; power_fail_n = 1'b1;
    cyc(20);
    rst <= 1'b0;
    cyc(3);
    rd(REG_CTRL, v); chk("ctrl_rst", v, CTRL_RST_VAL);
    rd(4'hF, v); chk("unmapped", v, 0);
    wr(REG_SANITY, 0);
    t_warn = 0; t_rst = 0;
    for (i = 1; i <= 60; i++) begin
      cyc(1);
      if (mcu_warn_irq === 1'b1 && t_warn == 0) t_warn = i;
      if (mcu_reset === 1'b1 && t_rst == 0) t_rst = i;
    end
    chk("warn_cycle", t_warn, SAN - WRN);
    chk("reset_cycle", t_rst, SAN);
    t_warn = 0;
    for (i = 0; i < 150; i++) begin
      @(posedge core_clk);
      send_char <= (i % 75 == 0); local_char_rx <= (i % 75 == 25); remote_char_rx <= (i % 75 == 50);
      #1 if (mcu_warn_irq !== 1'b0 || mcu_reset !== 1'b0) t_warn++;
    end
    chk("quiet", t_warn, 0);
    wr(REG_CTRL, 32'h0000_0020);
    cyc(2); chk("master_n", master_indication_n, 0);
    oob_msg <= 8'hA5; oob_msg_valid <= 1'b1;
    @(posedge core_clk);
    oob_msg_valid <= 1'b0;
    t_rst = 0;
    for (i = 0; i < 12; i++) begin
      #1 if (cpu_ctl.reset === 1'b1) t_rst++;
      @(posedge core_clk);
    end
    chk("oob_reset", t_rst, CPU_RST_CYC);
    rd(REG_OOB, v); chk("oob_full", v, 32'h0000_01A5);
    rd(REG_OOB, v); chk("oob_clear", v, 32'h0000_00A5);
    wr(REG_CTRL, 32'h0000_000E);
    cyc(3); chk("cpu_ctl", cpu_ctl, 4'h7);
    chk("jam_out", jam_status_out, 1);
    board <= 8'h5C;
    cyc(7); chk("disp", cpu_stat_disp.board, 8'h5C);
    chk("red", led_red, 1);
    wr(REG_CTRL, 32'h0000_0000);
    twin_jam_in <= 1'b1; board <= 8'h33;
    cyc(6); chk("hold", cpu_stat_disp.board, 8'h5C);
    chk("leds", {led_red, led_green_sync, led_green_act}, 3'b011);
    rd(REG_BOARD, v); chk("board_reg", v, 32'h0000_0033);
    wr(REG_CTRL, 32'h0000_0002);
    cyc(4); chk("twin_jam", cpu_ctl.jam, 0);
    twin_jam_in <= 1'b0; port3_txd <= 1'b0; scc_a_txd <= 1'b0; local_rxd <= 1'b0;
    cyc(5); chk("cha", {port3_rxd, scc_a_rxd, local_txd}, 0);
    twin_jam_in <= 1'b1; chk("rejam", cpu_ctl.jam, 1);
    cyc(4); chk("jam_drop", cpu_ctl.jam, 0);
    for (i = 0; i < 3; i++) begin
      wr(REG_CTRL, 32'(i) << CTRL_CHB_LO);
      scc_b_txd <= 1'b0; rs232_rxd <= (i != 1); rs422_rxd <= (i != 2);
      cyc(4); chk("chb_rx", scc_b_rxd, 0);
      chk("chb_tx", {rs232_txd, rs422_txd}, {i != 1, i != 2});
      scc_b_txd <= 1'b1;
    end
    wr(REG_CTRL, 32'h0000_0180);
    rs232_rxd <= 1'b0;
    cyc(5); chk("bypass", {rs232_txd, scc_b_rxd, cpu_chb_rxd}, 3'b010);
    wr(REG_CTRL, 32'h0000_0040);
    split_in <= 1'b1; strap_captive <= 1'b1;
    cyc(4); chk("split_out", split_out, 1);
    rd(REG_STATUS, v); chk("status", v & 32'h0000_0060, 32'h0000_0060);
    wr(REG_ID_INDEX, 0);
    wr(REG_ID_DATA, 32'h1234_5678);
    pb(1'b1, 24'h00_0000); chk("id", {v, f[2:1]}, {32'h1234_5678, 2'b10});
    pb_fw_rdata <= 32'h0000_0007; fw_parity_mode <= 1'b1;
    pb(1'b0, 24'h1F_FFFC); chk("fw_par", {v, f}, {32'h0000_0007, 3'b111});
    fw_parity_mode <= 1'b0;
    pb(1'b0, 24'h00_0004); chk("fw_nopar", f[2:1], 2'b10);
    pb(1'b0, 24'h20_0000); chk("fw_range", f[2], 0);
    mcu_xstrobe <= 1'b1;
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk);
      mcu_xaddr <= (i == 0) ? 16'h7FFF : (i == 1) ? 16'h8000 : (i == 2) ? 16'h9FFF : 16'hA000;
      cyc(1); chk("decode", {sram_sel, eeprom_sel}, (i == 0) ? 2'b10 : (i == 3) ? 2'b00 : 2'b01);
    end
    power_fail_n <= 1'b0;
    cyc(5); chk("pf_act", {led_green_act, cpu_ctl}, 0);
    power_fail_n <= 1'b1;
    cyc(5);
    rd(REG_CTRL, v); chk("pf_ctrl", v, CTRL_RST_VAL);
    end_of_test();
  end
endmodule : rts_supervisor_tb
`default_nettype wire
